// ==== sdcmd_pkg.sv ====
package sdcmd_pkg;

   // ==========================================================
   // Widths and fixed positions
   localparam int DQ_W           = 8;
   localparam int COL_W          = 9;
   localparam int ADDR_W         = 13;
   localparam int BANKS          = 4;
   localparam int BANK_W         = 2;
   localparam int RD_STAGES      = 2;
   localparam int AUTO_CLOSE_POS = 10;

   typedef logic [COL_W-1:0]  sdcmd_col_t;
   typedef logic [2:0]        sdcmd_bl_t;
   typedef logic [BANKS-1:0]  sdcmd_banks_t;

   // ==========================================================
   // Burst length codes and the matching wrap masks
   localparam sdcmd_bl_t  BL_1      = 3'h0;
   localparam sdcmd_bl_t  BL_2      = 3'h1;
   localparam sdcmd_bl_t  BL_4      = 3'h2;
   localparam sdcmd_bl_t  BL_8      = 3'h3;
   localparam sdcmd_bl_t  BL_FULL   = 3'h7;
   localparam sdcmd_col_t MASK_1    = 9'h000;
   localparam sdcmd_col_t MASK_2    = 9'h001;
   localparam sdcmd_col_t MASK_4    = 9'h003;
   localparam sdcmd_col_t MASK_8    = 9'h007;
   localparam sdcmd_col_t MASK_FULL = 9'h1ff;
   localparam sdcmd_col_t IDX_ZERO  = 9'h000;
   localparam sdcmd_col_t IDX_ONE   = 9'h001;

   // ==========================================================
   // Strobe patterns {row, column, write enable}, chip select low
   localparam logic [2:0] PINS_MRS   = 3'h0;
   localparam logic [2:0] PINS_REF   = 3'h1;
   localparam logic [2:0] PINS_PRE   = 3'h2;
   localparam logic [2:0] PINS_ACT   = 3'h3;
   localparam logic [2:0] PINS_WRITE = 3'h4;
   localparam logic [2:0] PINS_READ  = 3'h5;
   localparam logic [2:0] PINS_STOP  = 3'h6;
   localparam logic [2:0] PINS_NOP   = 3'h7;

   localparam sdcmd_banks_t ALL_BANKS = 4'hf;
   localparam sdcmd_banks_t NO_BANKS  = 4'h0;
   localparam logic [DQ_W-1:0] DQ_IDLE = 8'h00;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      CMD_DESEL = 4'h0,
      CMD_NOP   = 4'h1,
      CMD_ACT   = 4'h2,
      CMD_READ  = 4'h3,
      CMD_WRITE = 4'h4,
      CMD_PRE   = 4'h5,
      CMD_STOP  = 4'h6,
      CMD_REF   = 4'h7,
      CMD_MRS   = 4'h8
   } sdcmd_cmd_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } sdcmd_state_e;

   typedef struct packed {
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
   } sdcmd_pins_s;

   typedef struct packed {
      logic            valid;
      logic [DQ_W-1:0] data;
   } sdcmd_rd_s;

endpackage

// ==== sdcmd_burst_addr.sv ====
`timescale 1ns/1ps
module sdcmd_burst_addr (
   input  wire sdcmd_pkg::sdcmd_col_t startCol,
   input  wire sdcmd_pkg::sdcmd_col_t burstIdx,
   input  wire sdcmd_pkg::sdcmd_col_t burstMask,
   input  wire logic                  interleave,
   output sdcmd_pkg::sdcmd_col_t      col
);
   import sdcmd_pkg::*;

   sdcmd_col_t sum;

   // ==========================================================
   // Column within the burst; upper bits never change
   always_comb begin
      sum = startCol + burstIdx;
      if (interleave) begin
         col = (startCol & ~burstMask) | ((startCol ^ burstIdx) & burstMask);
      end else begin
         col = (startCol & ~burstMask) | (sum & burstMask);
      end
   end

endmodule

// ==== sdcmd_core.sv ====
// Contract
// - Write interrupting write restarts full burst
// - Read ends write burst same cycle
// - Burst stop ends burst, bank open
// - Stop: read drains latency, writes ignored
// - Sequential order wraps inside burst length
// - Interleaved order XORs low column bits with the beat index
// - Auto-close bit selects auto-precharge
// - Read auto-precharge starts with last read beat, whatever the latency
// - Write auto-precharge one clock after last
// - Precharge decode; bank select chooses bank
// - Self refresh entry decode, banks idle
// - Self refresh ignores all but enable
// - Enable low while idle: power down
// - No-op and deselect keep burst running
// - Enable low while active suspends clock
// - Read decode, address gives start column
`timescale 1ns/1ps
module sdcmd_core (
   input  wire logic                        clk,
   input  wire logic                        nrst,
   input  wire logic                        cke,
   input  wire sdcmd_pkg::sdcmd_pins_s      cmdPins,
   input  wire logic [sdcmd_pkg::BANK_W-1:0] bankSel,
   input  wire logic [sdcmd_pkg::ADDR_W-1:0] addr,
   input  wire logic [sdcmd_pkg::DQ_W-1:0]   dqIn,
   output logic [sdcmd_pkg::DQ_W-1:0]        dqOut,
   output logic                             dqOeN,
   input  wire sdcmd_pkg::sdcmd_bl_t        burstLenCode,
   input  wire logic                        interleaveMode,
   input  wire logic                        readLatency3,
   output sdcmd_pkg::sdcmd_col_t            memCol,
   output logic [sdcmd_pkg::BANK_W-1:0]     memBank,
   output logic                             memWrEn,
   output logic [sdcmd_pkg::DQ_W-1:0]        memWrData,
   output logic                             memRdEn,
   input  wire logic [sdcmd_pkg::DQ_W-1:0]   memRdData,
   output sdcmd_pkg::sdcmd_banks_t          bankOpen,
   output sdcmd_pkg::sdcmd_banks_t          prechargeStart,
   output logic                             selfRefresh,
   output logic                             powerDown,
   output logic                             clockSuspend
);
   import sdcmd_pkg::*;

   // ==========================================================
   // State
   sdcmd_state_e          stReg, stNext;
   sdcmd_col_t            idxReg, idxNext;
   sdcmd_col_t            startReg, startNext;
   logic [BANK_W-1:0]     bBankReg, bBankNext;
   logic                  apReg, apNext;
   logic                  wrPreReg, wrPreNext;
   logic [BANK_W-1:0]     wrPreBankReg, wrPreBankNext;
   sdcmd_col_t            memColReg, memColNext;
   logic [BANK_W-1:0]     memBankReg, memBankNext;
   logic                  memWrEnReg, memWrEnNext;
   logic [DQ_W-1:0]       memWrDataReg, memWrDataNext;
   logic                  memRdEnReg, memRdEnNext;
   sdcmd_banks_t          bankOpenReg, bankOpenNext;
   sdcmd_banks_t          prechReg, prechNext;
   logic                  srReg, srNext;
   logic                  pdReg, pdNext;
   logic                  suspReg, suspNext;
   logic [DQ_W-1:0]       dqOutReg, dqOutNext;
   logic                  dqOeNReg, dqOeNNext;
   sdcmd_rd_s             pipeReg [RD_STAGES];
   sdcmd_rd_s             pipeNext [RD_STAGES];

   sdcmd_cmd_e            cmd;
   sdcmd_col_t            blMask;
   sdcmd_col_t            burstCol;
   sdcmd_rd_s             rdSel;
   logic                  run;
   logic                  fullPage;
   logic                  anyActive;
   logic                  srEnter;

   // ==========================================================
   // Command decode
   always_comb begin
      if (cmdPins.csN) begin
         cmd = CMD_DESEL;
      end else begin
         case ({cmdPins.rasN, cmdPins.casN, cmdPins.weN})
            PINS_MRS:   cmd = CMD_MRS;
            PINS_REF:   cmd = CMD_REF;
            PINS_PRE:   cmd = CMD_PRE;
            PINS_ACT:   cmd = CMD_ACT;
            PINS_WRITE: cmd = CMD_WRITE;
            PINS_READ:  cmd = CMD_READ;
            PINS_STOP:  cmd = CMD_STOP;
            default:    cmd = CMD_NOP;
         endcase
      end
   end

   // Burst length to wrap mask; unknown codes behave as length one
   always_comb begin
      case (burstLenCode)
         BL_2:    blMask = MASK_2;
         BL_4:    blMask = MASK_4;
         BL_8:    blMask = MASK_8;
         BL_FULL: blMask = MASK_FULL;
         default: blMask = MASK_1;
      endcase
   end

   assign fullPage  = (burstLenCode == BL_FULL);
   assign run       = ~suspReg & ~pdReg & ~srReg;
   assign anyActive = (bankOpenReg != NO_BANKS) | (stReg != ST_IDLE);

   sdcmd_burst_addr u_addr (
      .startCol   (startReg),
      .burstIdx   (idxReg),
      .burstMask  (blMask),
      .interleave (interleaveMode),
      .col        (burstCol)
   );

   // ==========================================================
   // Low-power modes; the internal clock stops one edge after enable falls
   always_comb begin
      srEnter  = run & ~cke & (cmd == CMD_REF) & ~anyActive;
      srNext   = srReg ? ~cke : srEnter;
      pdNext   = pdReg ? ~cke :
                 (run & ~cke & ~anyActive & ~srEnter &
                  ((cmd == CMD_NOP) | (cmd == CMD_DESEL)));
      suspNext = ~srReg & ~pdReg & ~cke & anyActive;
   end

   // ==========================================================
   // Burst engine and bank bookkeeping
   always_comb begin
      stNext        = stReg;
      idxNext       = idxReg;
      startNext     = startReg;
      bBankNext     = bBankReg;
      apNext        = apReg;
      wrPreNext     = wrPreReg;
      wrPreBankNext = wrPreBankReg;
      memColNext    = memColReg;
      memBankNext   = memBankReg;
      memWrDataNext = memWrDataReg;
      memRdEnNext   = memRdEnReg; // Held so a suspended read is not dropped
      memWrEnNext   = 1'b0;
      prechNext     = NO_BANKS;
      bankOpenNext  = bankOpenReg;
      if (run) begin
         memRdEnNext = 1'b0;
         wrPreNext   = 1'b0;
         // Write auto-precharge starts on the edge after the last data
         if (wrPreReg) begin
            prechNext[wrPreBankReg] = 1'b1;
         end
         // Burst continues under no-op, deselect, activate, refresh, mode set and precharge of another bank
         if (stReg != ST_IDLE) begin
            memColNext    = burstCol;
            memBankNext   = bBankReg;
            memRdEnNext   = (stReg == ST_READ);
            memWrEnNext   = (stReg == ST_WRITE);
            memWrDataNext = dqIn;
            idxNext       = idxReg + IDX_ONE;
            if (!fullPage && (idxReg == blMask)) begin
               stNext = ST_IDLE;
               if (apReg && stReg == ST_READ) begin
                  prechNext[bBankReg] = 1'b1;
               end
               if (apReg && stReg == ST_WRITE) begin
                  wrPreNext     = 1'b1;
                  wrPreBankNext = bBankReg;
               end
            end
         end
         case (cmd)
            CMD_ACT: begin
               bankOpenNext[bankSel] = 1'b1;
            end
            CMD_READ, CMD_WRITE: begin
               // A new access drops what is left of any burst
               startNext     = addr[COL_W-1:0];
               bBankNext     = bankSel;
               idxNext       = IDX_ONE;
               apNext        = addr[AUTO_CLOSE_POS];
               memColNext    = addr[COL_W-1:0];
               memBankNext   = bankSel;
               memRdEnNext   = (cmd == CMD_READ);
               memWrEnNext   = (cmd == CMD_WRITE);
               memWrDataNext = dqIn;
               prechNext     = NO_BANKS;
               wrPreNext     = 1'b0;
               if (wrPreReg) begin
                  prechNext[wrPreBankReg] = 1'b1;
               end
               if (blMask == MASK_1) begin
                  stNext = ST_IDLE;
                  if (addr[AUTO_CLOSE_POS] && cmd == CMD_READ) begin
                     prechNext[bankSel] = 1'b1;
                  end
                  if (addr[AUTO_CLOSE_POS] && cmd == CMD_WRITE) begin
                     wrPreNext     = 1'b1;
                     wrPreBankNext = bankSel;
                  end
               end else begin
                  stNext = (cmd == CMD_READ) ? ST_READ : ST_WRITE;
               end
            end
            CMD_STOP: begin
               // Bank stays open; data already in the read pipe drains
               stNext      = ST_IDLE;
               memRdEnNext = 1'b0;
               memWrEnNext = 1'b0;
            end
            CMD_PRE: begin
               if (addr[AUTO_CLOSE_POS]) begin
                  prechNext = ALL_BANKS;
               end else begin
                  prechNext[bankSel] = 1'b1;
               end
               if (addr[AUTO_CLOSE_POS] || bankSel == bBankReg) begin
                  stNext      = ST_IDLE;
                  memRdEnNext = 1'b0;
                  memWrEnNext = 1'b0;
               end
            end
            default: begin
            end
         endcase
         bankOpenNext = bankOpenNext & ~prechNext;
      end
   end

   // ==========================================================
   // Read latency pipeline; frozen while the internal clock is off
   for (genvar i = 0; i < RD_STAGES; i++) begin : g_stage
      sdcmd_rd_s stIn;
      if (i == 0) begin : g_first
         assign stIn = '{valid: memRdEnReg, data: memRdData};
      end else begin : g_rest
         assign stIn = pipeReg[i-1];
      end
      always_comb begin
         pipeNext[i] = run ? stIn : pipeReg[i];
      end
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            pipeReg[i] <= '{valid: 1'b0, data: DQ_IDLE};
         end else begin
            pipeReg[i] <= pipeNext[i];
         end
      end
   end

   // Output stage picks the tap for the programmed latency
   always_comb begin
      rdSel     = readLatency3 ? pipeReg[RD_STAGES-1] : pipeReg[0];
      dqOutNext = run ? rdSel.data : dqOutReg;
      dqOeNNext = run ? ~rdSel.valid : dqOeNReg;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stReg        <= ST_IDLE;
         idxReg       <= IDX_ZERO;
         startReg     <= IDX_ZERO;
         bBankReg     <= '0;
         apReg        <= 1'b0;
         wrPreReg     <= 1'b0;
         wrPreBankReg <= '0;
         memColReg    <= IDX_ZERO;
         memBankReg   <= '0;
         memWrEnReg   <= 1'b0;
         memWrDataReg <= DQ_IDLE;
         memRdEnReg   <= 1'b0;
         bankOpenReg  <= NO_BANKS;
         prechReg     <= NO_BANKS;
         srReg        <= 1'b0;
         pdReg        <= 1'b0;
         suspReg      <= 1'b0;
         dqOutReg     <= DQ_IDLE;
         dqOeNReg     <= 1'b1;
      end else begin
         stReg        <= stNext;
         idxReg       <= idxNext;
         startReg     <= startNext;
         bBankReg     <= bBankNext;
         apReg        <= apNext;
         wrPreReg     <= wrPreNext;
         wrPreBankReg <= wrPreBankNext;
         memColReg    <= memColNext;
         memBankReg   <= memBankNext;
         memWrEnReg   <= memWrEnNext;
         memWrDataReg <= memWrDataNext;
         memRdEnReg   <= memRdEnNext;
         bankOpenReg  <= bankOpenNext;
         prechReg     <= prechNext;
         srReg        <= srNext;
         pdReg        <= pdNext;
         suspReg      <= suspNext;
         dqOutReg     <= dqOutNext;
         dqOeNReg     <= dqOeNNext;
      end
   end

   assign dqOut          = dqOutReg;
   assign dqOeN          = dqOeNReg;
   assign memCol         = memColReg;
   assign memBank        = memBankReg;
   assign memWrEn        = memWrEnReg;
   assign memWrData      = memWrDataReg;
   assign memRdEn        = memRdEnReg;
   assign bankOpen       = bankOpenReg;
   assign prechargeStart = prechReg;
   assign selfRefresh    = srReg;
   assign powerDown      = pdReg;
   assign clockSuspend   = suspReg;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_rd_cl2;
      run && cmd == CMD_READ && !readLatency3;
   endsequence
   sequence s_running2;
      (!clockSuspend)[*2];
   endsequence

   a_sr_entry: assert property (srEnter |=> selfRefresh && !memWrEn)
      else $error("self refresh not entered");
   a_sr_exit: assert property (selfRefresh && cke |=> !selfRefresh)
      else $error("self refresh not left");
   a_susp_freeze: assert property (clockSuspend |=> !memWrEn && $stable(memCol))
      else $error("operation ran while suspended");
   a_susp_entry: assert property (run && !cke && anyActive |=> clockSuspend)
      else $error("clock suspend missed");
   a_pre_all: assert property (run && cmd == CMD_PRE && addr[AUTO_CLOSE_POS] |=> bankOpen == NO_BANKS)
      else $error("precharge all left a bank open");
   a_pre_one: assert property (run && cmd == CMD_PRE |=> prechargeStart[$past(bankSel)])
      else $error("addressed bank not precharged");
   a_rd_latency: assert property (s_rd_cl2 ##1 s_running2 |=> !dqOeN)
      else $error("read data late");
   a_wr_start: assert property (run && cmd == CMD_WRITE |=> memWrEn && memCol == $past(addr[COL_W-1:0]))
      else $error("write not restarted at new column");
   a_rd_kills_wr: assert property (run && stReg == ST_WRITE && cmd == CMD_READ |=> !memWrEn && memRdEn)
      else $error("write continued after read");
   a_stop_ends: assert property (run && cmd == CMD_STOP |=> !memWrEn && !memRdEn && $stable(bankOpen))
      else $error("burst stop did not end burst");
   a_nop_keeps: assert property (run && stReg != ST_IDLE && cmd == CMD_NOP |=> memRdEn || memWrEn)
      else $error("no-op broke the burst");

endmodule

// ==== sdcmd_ctrl_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Controller stand-in: drives strobes, bank, address, data
module sdcmd_ctrl_model (
   input  wire logic                         clk,
   output logic                              cke,
   output sdcmd_pkg::sdcmd_pins_s            cmdPins,
   output logic [sdcmd_pkg::BANK_W-1:0]      bankSel,
   output logic [sdcmd_pkg::ADDR_W-1:0]      addr,
   output logic [sdcmd_pkg::DQ_W-1:0]        dqIn
);
   import sdcmd_pkg::*;

   // Quiet bus at time zero, clock running
   initial begin
      cke = 1'b1;
      cmdPins = 4'hf;
      bankSel = 2'h0;
      addr = 13'h0000;
      dqIn = 8'h00;
   end

   // Strobe pattern for each command, chip select low except deselect
   function automatic sdcmd_pins_s pinsOf(input sdcmd_cmd_e c);
      case (c)
         CMD_NOP:   return {1'b0, PINS_NOP};
         CMD_ACT:   return {1'b0, PINS_ACT};
         CMD_READ:  return {1'b0, PINS_READ};
         CMD_WRITE: return {1'b0, PINS_WRITE};
         CMD_PRE:   return {1'b0, PINS_PRE};
         CMD_STOP:  return {1'b0, PINS_STOP};
         CMD_REF:   return {1'b0, PINS_REF};
         CMD_MRS:   return {1'b0, PINS_MRS};
         default:   return 4'hf;
      endcase
   endfunction

   // One command per edge; cke rides along so exits carry a no-op
   task automatic issue(input sdcmd_cmd_e c, input logic [1:0] b, input logic [12:0] a,
                        input logic [7:0] d, input logic k = 1'b1);
      @(posedge clk);
      cmdPins <= pinsOf(c);
      bankSel <= b;
      addr    <= a;
      dqIn    <= d;
      cke     <= k;
   endtask

   // Next write word on the following edge
   task automatic wdata(input logic [7:0] d);
      issue(CMD_NOP, 2'h0, 13'h1fff, d);
   endtask

   // Deselect; released lines toggle so a stale value never looks valid
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         cmdPins <= 4'hf;
         addr    <= ~addr;
         dqIn    <= ~dqIn;
      end
   endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import sdcmd_pkg::*;

   // ==========================================================
   // Signals
   logic              clk;
   logic              nrst;
   logic              cke;
   sdcmd_pins_s       cmdPins;
   logic [1:0]        bankSel;
   logic [12:0]       addr;
   logic [7:0]        dqIn;
   logic [7:0]        dqOut;
   logic              dqOeN;
   sdcmd_bl_t         burstLenCode;
   logic              interleaveMode;
   logic              readLatency3;
   sdcmd_col_t        memCol;
   logic [1:0]        memBank;
   logic              memWrEn;
   logic [7:0]        memWrData;
   logic              memRdEn;
   logic [7:0]        memRdData;
   sdcmd_banks_t      bankOpen;
   sdcmd_banks_t      prechargeStart;
   logic              selfRefresh;
   logic              powerDown;
   logic              clockSuspend;
   int                errors;
   int                tests_run;
   logic [16:0]       wrQ[$];
   sdcmd_col_t        colQ[$];
   logic [7:0]        rdQ[$];
   sdcmd_banks_t      preQ[$];
   logic [16:0]       ew[$];
   sdcmd_col_t        ec[$];

   sdcmd_ctrl_model ctrl (.clk(clk), .cke(cke), .cmdPins(cmdPins), .bankSel(bankSel),
                          .addr(addr), .dqIn(dqIn));
   sdcmd_core dut_u (.clk(clk), .nrst(nrst), .cke(cke), .cmdPins(cmdPins), .bankSel(bankSel),
      .addr(addr), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN), .burstLenCode(burstLenCode),
      .interleaveMode(interleaveMode), .readLatency3(readLatency3), .memCol(memCol),
      .memBank(memBank), .memWrEn(memWrEn), .memWrData(memWrData), .memRdEn(memRdEn),
      .memRdData(memRdData), .bankOpen(bankOpen), .prechargeStart(prechargeStart),
      .selfRefresh(selfRefresh), .powerDown(powerDown), .clockSuspend(clockSuspend));

   // Storage array answers in the same cycle with a column-derived byte
   assign memRdData = memCol[7:0] ^ 8'h5a;

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Log every beat mid-cycle, where outputs have settled
   always @(negedge clk) begin
      if (nrst === 1'b1) begin
         if (memWrEn === 1'b1) wrQ.push_back({memCol, memWrData});
         if (memRdEn === 1'b1 && clockSuspend !== 1'b1) colQ.push_back(memCol);
         if (dqOeN === 1'b0) rdQ.push_back(dqOut);
         if (prechargeStart !== 4'h0) preQ.push_back(prechargeStart);
      end
   end

   // ==========================================================
   // Compare and report
   task automatic chkVal(input logic [16:0] got, input logic [16:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic clearQ();
      wrQ.delete();
      colQ.delete();
      rdQ.delete();
      preQ.delete();
      ew.delete();
      ec.delete();
   endtask

   // Written beats against the expected list
   task automatic chkWr();
      chkVal(17'(wrQ.size()), 17'(ew.size()));
      foreach (ew[i]) if (i < wrQ.size()) chkVal(wrQ[i], ew[i]);
   endtask

   // Read columns and returned bytes against the expected columns
   task automatic chkRd();
      chkVal(17'(colQ.size()), 17'(ec.size()));
      chkVal(17'(rdQ.size()), 17'(ec.size()));
      foreach (ec[i]) begin
         if (i < colQ.size()) chkVal(17'(colQ[i]), 17'(ec[i]));
         if (i < rdQ.size()) chkVal(17'(rdQ[i]), 17'(ec[i][7:0] ^ 8'h5a));
      end
   endtask

   function automatic sdcmd_col_t seqCol(input sdcmd_col_t s, input int n, input sdcmd_col_t m);
      return (s & ~m) | ((s + 9'(n)) & m);
   endfunction

   // Scenario commands reach the controller stand-in through this funnel; wdata and idle are called on it directly
   task automatic send(input sdcmd_cmd_e c, input logic [1:0] b, input logic [12:0] a,
                       input logic [7:0] d, input logic k = 1'b1);
      ctrl.issue(c, b, a, d, k);
   endtask

   // ==========================================================
   // Scenarios
   task automatic s_seq_write();
      clearQ();
      send(CMD_ACT, 2'h1, 13'h0004, 8'h00);
      ctrl.idle(2);
      send(CMD_WRITE, 2'h1, 13'h0006, 8'h10);
      for (int i = 1; i < 4; i++) ctrl.wdata(8'h10 + 8'(i));
      ctrl.idle(8);
      for (int i = 0; i < 4; i++) ew.push_back({seqCol(9'h006, i, MASK_4), 8'h10 + 8'(i)});
      chkWr();
      chkVal(17'(memBank), 17'h1);
   endtask

   task automatic s_inter_read();
      clearQ();
      burstLenCode <= BL_8;
      interleaveMode <= 1'b1;
      readLatency3 <= 1'b1;
      ctrl.idle(1);
      send(CMD_READ, 2'h1, 13'h000d, 8'h00);
      ctrl.idle(14);
      for (int i = 0; i < 8; i++) ec.push_back(9'h00d ^ 9'(i));
      chkRd();
      interleaveMode <= 1'b0;
      readLatency3 <= 1'b0;
      burstLenCode <= BL_4;
   endtask

   task automatic s_wr_wr();
      clearQ();
      send(CMD_WRITE, 2'h1, 13'h0010, 8'h20);
      ctrl.wdata(8'h21);
      send(CMD_WRITE, 2'h1, 13'h0028, 8'h30);
      for (int i = 1; i < 4; i++) ctrl.wdata(8'h30 + 8'(i));
      ctrl.idle(8);
      ew = '{{9'h010, 8'h20}, {9'h011, 8'h21}, {9'h028, 8'h30}, {9'h029, 8'h31},
             {9'h02a, 8'h32}, {9'h02b, 8'h33}};
      chkWr();
   endtask

   task automatic s_wr_rd();
      clearQ();
      send(CMD_WRITE, 2'h1, 13'h0040, 8'h40);
      send(CMD_READ, 2'h1, 13'h0044, 8'h41);
      ctrl.idle(10);
      ew = '{{9'h040, 8'h40}};
      ec = '{9'h044, 9'h045, 9'h046, 9'h047};
      chkWr();
      chkRd();
   endtask

   task automatic s_stop();
      clearQ();
      burstLenCode <= BL_FULL;
      send(CMD_READ, 2'h1, 13'h01fe, 8'h00);
      ctrl.idle(3);
      send(CMD_STOP, 2'h1, 13'h0000, 8'h00);
      ctrl.idle(8);
      ec = '{9'h1fe, 9'h1ff, 9'h000, 9'h001};
      chkRd();
      chkVal(17'(bankOpen[1]), 17'h1);
      clearQ();
      send(CMD_WRITE, 2'h1, 13'h0000, 8'h50);
      ctrl.wdata(8'h51);
      ctrl.wdata(8'h52);
      send(CMD_STOP, 2'h1, 13'h0000, 8'h53);
      ctrl.idle(8);
      ew = '{{9'h000, 8'h50}, {9'h001, 8'h51}, {9'h002, 8'h52}};
      chkWr();
      burstLenCode <= BL_2;
   endtask

   task automatic s_autopre();
      clearQ();
      send(CMD_ACT, 2'h2, 13'h0000, 8'h00);
      ctrl.idle(2);
      send(CMD_WRITE, 2'h2, 13'h0400, 8'h60);
      ctrl.wdata(8'h61);
      ctrl.idle(8);
      chkVal(17'(preQ.size()), 17'h1);
      if (preQ.size() > 0) chkVal(17'(preQ[0]), 17'h4);
      chkVal(17'(bankOpen[2]), 17'h0);
      clearQ();
      burstLenCode <= BL_4;
      send(CMD_ACT, 2'h3, 13'h0000, 8'h00);
      ctrl.idle(2);
      send(CMD_READ, 2'h3, 13'h0408, 8'h00);
      ctrl.idle(10);
      chkVal(17'(preQ.size()), 17'h1);
      if (preQ.size() > 0) chkVal(17'(preQ[0]), 17'h8);
      chkVal(17'(rdQ.size()), 17'h4);
   endtask

   task automatic s_pre();
      // Single-beat write after a mode-set pattern, which must act as a no-op here
      clearQ();
      burstLenCode <= BL_1;
      send(CMD_MRS, 2'h0, 13'h0000, 8'h00);
      send(CMD_WRITE, 2'h1, 13'h0033, 8'h7e);
      ctrl.idle(3);
      ew = '{{9'h033, 8'h7e}};
      chkWr();
      for (int b = 0; b < 4; b++) send(CMD_ACT, 2'(b), 13'h0001, 8'h00);
      ctrl.idle(2);
      chkVal(17'(bankOpen), 17'hf);
      send(CMD_PRE, 2'h2, 13'h0000, 8'h00);
      ctrl.idle(2);
      chkVal(17'(bankOpen), 17'hb);
      send(CMD_PRE, 2'h0, 13'h0400, 8'h00);
      ctrl.idle(3);
      chkVal(17'(bankOpen), 17'h0);
   endtask

   task automatic s_modes();
      send(CMD_NOP, 2'h0, 13'h0000, 8'h00, 1'b0);
      ctrl.idle(2);
      chkVal(17'(powerDown), 17'h1);
      send(CMD_NOP, 2'h0, 13'h0000, 8'h00, 1'b1);
      ctrl.idle(2);
      chkVal(17'(powerDown), 17'h0);
      send(CMD_REF, 2'h0, 13'h0000, 8'h00, 1'b0);
      ctrl.idle(2);
      chkVal(17'(selfRefresh), 17'h1);
      send(CMD_ACT, 2'h0, 13'h0000, 8'h00, 1'b0);
      ctrl.idle(2);
      chkVal(17'(bankOpen), 17'h0);
      send(CMD_NOP, 2'h0, 13'h0000, 8'h00, 1'b1);
      ctrl.idle(3);
      chkVal(17'(selfRefresh), 17'h0);
      clearQ();
      burstLenCode <= BL_8;
      send(CMD_ACT, 2'h0, 13'h0000, 8'h00);
      ctrl.idle(2);
      send(CMD_WRITE, 2'h0, 13'h0000, 8'h70);
      ctrl.wdata(8'h71);
      send(CMD_NOP, 2'h0, 13'h1fff, 8'h72, 1'b0);
      send(CMD_WRITE, 2'h0, 13'h0100, 8'h73, 1'b0);
      @(negedge clk);
      chkVal(17'(clockSuspend), 17'h1);
      send(CMD_NOP, 2'h0, 13'h1fff, 8'h74, 1'b1);
      ctrl.idle(12);
      chkVal(17'(clockSuspend), 17'h0);
      chkVal(17'(wrQ.size()), 17'h8);
      foreach (wrQ[i]) chkVal(17'(wrQ[i][16:8]), 17'(i));
   endtask

   // ==========================================================
   // Main sequence and hang guard
   initial begin
      errors = 0;
      tests_run = 0;
      nrst = 1'b0;
      burstLenCode = BL_4;
      interleaveMode = 1'b0;
      readLatency3 = 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      s_seq_write();
      s_inter_read();
      s_wr_wr();
      s_wr_rd();
      s_stop();
      s_autopre();
      s_pre();
      s_modes();
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      finish_test();
   end
endmodule
